// ### verilog/sbg_pkg.sv
// shared constants and types for the servo burst gate control
package sbg_pkg;
    // charging mode encoding
    typedef enum logic [0:0] {
        SBG_MODE_TRACK = 1'b0,
        SBG_MODE_SEEK = 1'b1
    } sbg_mode_type;

    // reset value of the latched charging mode
    localparam sbg_mode_type SBG_MODE_RESET = SBG_MODE_TRACK;

    // reset values of the gating, flag and burst registers
    localparam logic [3:0] SBG_GATE_RESET = 4'h0;
    localparam logic SBG_FLAG_RESET = 1'h0;
    localparam logic [3:0] SBG_BURST_RESET = 4'h0;

    // select bus bit positions
    localparam int SBG_SEL_ONE = 0;
    localparam int SBG_SEL_TWO = 1;
    localparam int SBG_SEL_THREE = 2;
    localparam int SBG_SEL_FOUR = 3;

    // charge rate codes: larger value charges faster
    localparam logic [1:0] SBG_RATE_SLOW = 2'h1;
    localparam logic [1:0] SBG_RATE_FAST = 2'h3;
    localparam logic [1:0] SBG_RATE_RESET = 2'h1;
endpackage : sbg_pkg

// ### verilog/sbg_obs_mux.sv
// observation routing for the four burst outputs
`timescale 1ns/1ps
module sbg_obs_mux
    import sbg_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    // control
    input wire logic observe_in,
    // internal pulse detector taps
    input wire logic diff_pos_in,
    input wire logic diff_neg_in,
    input wire logic zero_cross_in,
    input wire logic qual_delay_in,
    // peak detector levels
    input wire logic [3:0] peak_in,
    // burst outputs
    output logic [3:0] burst_out
);
    logic [3:0] burst_q;
    logic [3:0] burst_d;

    always_comb begin
        if (observe_in) begin
            burst_d = {qual_delay_in, zero_cross_in, diff_neg_in, diff_pos_in}; // [R8]
        end else begin
            burst_d = peak_in;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            burst_q <= SBG_BURST_RESET;
        end else begin
            burst_q <= burst_d;
        end
    end

    assign burst_out = burst_q;
endmodule : sbg_obs_mux

// ### verilog/sbg_gate_ctrl.sv
// pin decode of servo burst gating, discharge, observation and charging mode
//
// What this block does
// R1 - gate-select low, line one high, line three low latches track-follow mode
// R2 - gate-select low, line three high, line one low latches seek; both high forbidden
// R3 - no latch command decoded keeps the previously latched charging mode
// R4 - gate-select low with line two high enters observation mode
// R5 - gate-select low with line four high discharges all four burst capacitors
// R6 - gate-select high: each select line gates its own burst channel
// R7 - discharge, observation and track-follow latch may act in one state
// R8 - observation routes differentiator, zero-cross and delayed qualification outputs
// R9 - track-follow charges slower than seek
// R10 - charging mode starts as track-follow after reset
`timescale 1ns/1ps
module sbg_gate_ctrl
    import sbg_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    // controller pins
    input wire logic gate_select_in,
    input wire logic select_line_one_in,
    input wire logic select_line_two_in,
    input wire logic select_line_three_in,
    input wire logic select_line_four_in,
    // internal pulse detector taps
    input wire logic diff_pos_in,
    input wire logic diff_neg_in,
    input wire logic zero_cross_in,
    input wire logic qual_delay_in,
    input wire logic [3:0] peak_in,
    // channel control to analog
    output logic [3:0] channel_gate_out,
    output logic discharge_out,
    output logic observe_out,
    output logic seek_mode_out,
    output logic [1:0] charge_rate_out,
    output logic illegal_cmd_out,
    // burst outputs
    output logic burst_channel_one_out,
    output logic burst_channel_two_out,
    output logic burst_channel_three_out,
    output logic burst_channel_four_out
);
    // ******************************
    // decode
    // ******************************
    logic [3:0] sel;
    logic latch_track;
    logic latch_seek;
    logic illegal;
    logic want_discharge;
    logic want_observe;
    sbg_mode_type mode_q;
    sbg_mode_type mode_d;
    logic [3:0] gate_q;
    logic [3:0] gate_d;
    logic discharge_q;
    logic observe_q;
    logic [1:0] rate_q;
    logic [1:0] rate_d;
    logic illegal_q;
    logic [3:0] burst;

    // ******************************
    // functions
    // ******************************

    // a select line is a command only while gate-select is low
    function automatic logic cmd_line(input logic gate_sel, input logic [3:0] lines,
                                      input int pos);
        return !gate_sel && lines[pos];
    endfunction : cmd_line

    // gating lines reach the channels only while gate-select is high
    function automatic logic [3:0] gate_lines(input logic gate_sel, input logic [3:0] lines);
        logic [3:0] gated;
        gated = 4'h0;
        if (gate_sel) begin
            gated = lines;
        end
        return gated;
    endfunction : gate_lines

    // slower charge in track-follow keeps the detectors calm on noisy bursts
    function automatic logic [1:0] rate_of(input sbg_mode_type mode);
        logic [1:0] rate;
        rate = SBG_RATE_SLOW;
        if (mode == SBG_MODE_SEEK) begin
            rate = SBG_RATE_FAST;
        end
        return rate;
    endfunction : rate_of

    assign sel = {select_line_four_in, select_line_three_in, select_line_two_in,
                  select_line_one_in};

    // forbidden pair: hold mode rather than guess
    assign illegal = cmd_line(gate_select_in, sel, SBG_SEL_ONE)
                     && cmd_line(gate_select_in, sel, SBG_SEL_THREE); // [R2]
    assign latch_track = cmd_line(gate_select_in, sel, SBG_SEL_ONE)
                         && !sel[SBG_SEL_THREE]; // [R1]
    assign latch_seek = cmd_line(gate_select_in, sel, SBG_SEL_THREE)
                        && !sel[SBG_SEL_ONE]; // [R2]
    assign want_discharge = cmd_line(gate_select_in, sel, SBG_SEL_FOUR); // [R5] [R7]
    assign want_observe = cmd_line(gate_select_in, sel, SBG_SEL_TWO); // [R4] [R7]
    assign gate_d = gate_lines(gate_select_in, sel); // [R6]

    // ******************************
    // next charging mode
    // ******************************
    always_comb begin
        mode_d = mode_q; // [R3]
        if (latch_track) begin
            mode_d = SBG_MODE_TRACK; // [R1] [R7]
        end else if (latch_seek) begin
            mode_d = SBG_MODE_SEEK; // [R2]
        end
    end

    // rate follows the mode about to be latched, so both flops agree every cycle
    assign rate_d = rate_of(mode_d); // [R9]

    // ******************************
    // charging mode
    // ******************************
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            mode_q <= SBG_MODE_RESET; // [R10]
        end else begin
            mode_q <= mode_d;
        end
    end

    // ******************************
    // charge rate
    // ******************************
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rate_q <= SBG_RATE_RESET;
        end else begin
            rate_q <= rate_d; // [R9]
        end
    end

    // ******************************
    // channel gating
    // ******************************
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            gate_q <= SBG_GATE_RESET;
        end else begin
            gate_q <= gate_d; // [R6]
        end
    end

    // ******************************
    // discharge
    // ******************************
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            discharge_q <= SBG_FLAG_RESET;
        end else begin
            discharge_q <= want_discharge; // [R5]
        end
    end

    // ******************************
    // observation
    // ******************************
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            observe_q <= SBG_FLAG_RESET;
        end else begin
            observe_q <= want_observe; // [R4]
        end
    end

    // ******************************
    // refused command flag
    // ******************************
    // flag only reports; discharge and observation still act on a refused command
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            illegal_q <= SBG_FLAG_RESET;
        end else begin
            illegal_q <= illegal; // [R2]
        end
    end

    // ******************************
    // observation routing
    // ******************************
    // burst pins lag the control flops by one more register stage
    sbg_obs_mux u_obs (
        .ref_clk_in(ref_clk_in),
        .rst_b_in(rst_b_in),
        .observe_in(observe_q),
        .diff_pos_in(diff_pos_in),
        .diff_neg_in(diff_neg_in),
        .zero_cross_in(zero_cross_in),
        .qual_delay_in(qual_delay_in),
        .peak_in(peak_in),
        .burst_out(burst)
    );

    // ******************************
    // outputs
    // ******************************
    // every pin comes straight from a flop, no decode glitches reach the analog side
    assign channel_gate_out = gate_q;
    assign discharge_out = discharge_q;
    assign observe_out = observe_q;
    assign seek_mode_out = mode_q;
    assign charge_rate_out = rate_q;
    assign illegal_cmd_out = illegal_q;
    assign burst_channel_one_out = burst[0];
    assign burst_channel_two_out = burst[1];
    assign burst_channel_three_out = burst[2];
    assign burst_channel_four_out = burst[3];
endmodule : sbg_gate_ctrl

// ### testbench/sbg_gate_ctrl_asserts.sv
// pin decode checker for the servo burst gate control
`timescale 1ns/1ps
module sbg_gate_ctrl_asserts
    import sbg_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    // controller pins
    input wire logic gate_select_in,
    input wire logic select_line_one_in,
    input wire logic select_line_two_in,
    input wire logic select_line_three_in,
    input wire logic select_line_four_in,
    // internal taps and peak levels
    input wire logic diff_pos_in,
    input wire logic diff_neg_in,
    input wire logic zero_cross_in,
    input wire logic qual_delay_in,
    input wire logic [3:0] peak_in,
    // channel control
    input wire logic [3:0] channel_gate_out,
    input wire logic discharge_out,
    input wire logic observe_out,
    input wire logic seek_mode_out,
    input wire logic [1:0] charge_rate_out,
    input wire logic illegal_cmd_out,
    // burst outputs
    input wire logic burst_channel_one_out,
    input wire logic burst_channel_two_out,
    input wire logic burst_channel_three_out,
    input wire logic burst_channel_four_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_b_in);
    wire logic g = gate_select_in;
    wire logic s1 = select_line_one_in;
    wire logic s2 = select_line_two_in;
    wire logic s3 = select_line_three_in;
    wire logic s4 = select_line_four_in;
    wire logic [3:0] tap = {diff_pos_in, diff_neg_in, zero_cross_in, qual_delay_in};
    wire logic [3:0] bo = {burst_channel_one_out, burst_channel_two_out,
        burst_channel_three_out, burst_channel_four_out};
    // peak levels in the same channel order as bo, channel one on top
    wire logic [3:0] pk = {peak_in[0], peak_in[1], peak_in[2], peak_in[3]};
    chk_track_latch: assert property (!g && s1 && !s3 |=> !seek_mode_out)
        else $error("track latch missed");
    chk_seek_latch: assert property (!g && s3 && !s1 |=> seek_mode_out)
        else $error("seek latch missed");
    chk_mode_hold: assert property (!(!g && (s1 ^ s3)) |=> $stable(seek_mode_out))
        else $error("mode changed without latch");
    chk_observe_on: assert property (!g && s2 |=> observe_out)
        else $error("observe missed");
    chk_discharge_all: assert property (!g && s4 |=> discharge_out)
        else $error("discharge missed");
    chk_gate_map: assert property (g |=> channel_gate_out == $past({s4, s3, s2, s1}))
        else $error("gate map wrong");
    chk_gate_idle: assert property (!g |=> channel_gate_out == 4'h0)
        else $error("gate while decoding");
    chk_tap_route: assert property (observe_out |=> bo == $past(tap))
        else $error("tap routing wrong");
    chk_rate_order: assert property (charge_rate_out ==
        (seek_mode_out ? SBG_RATE_FAST : SBG_RATE_SLOW))
        else $error("charge rate wrong");
    chk_peak_pass: assert property (!observe_out |=> bo == $past(pk))
        else $error("peak levels not passed");
    chk_refused_flag: assert property (illegal_cmd_out == $past(!g && s1 && s3))
        else $error("refused flag wrong");
endmodule : sbg_gate_ctrl_asserts
bind sbg_gate_ctrl sbg_gate_ctrl_asserts u_chk (.*);

// ### testbench/sbg_ctrl_model.sv
// servo controller model driving gate select and select lines
`timescale 1ns/1ps
module sbg_ctrl_model (
    // clock
    input wire logic ref_clk_in,
    // wanted levels: bit 4 gate-select, bits 3..0 lines four..one
    input wire logic [4:0] cmd_in,
    // levels as driven onto the device pins
    output logic [4:0] pins_out
);
    // line three dropped if it would pair with line one while decoding
    always_ff @(posedge ref_clk_in) begin
        pins_out <= cmd_in & ((!cmd_in[4] && cmd_in[0]) ? 5'h1b : 5'h1f);
    end
endmodule : sbg_ctrl_model

// ### testbench/sbg_gate_ctrl_bench.sv
// self-checking bench for the servo burst gate control
`timescale 1ns/1ps
module sbg_gate_ctrl_bench;
    import sbg_pkg::*;
    logic ref_clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic [4:0] cmd = 5'h00;
    logic [4:0] p;
    logic [3:0] tp = 4'h0;
    logic [3:0] pk = 4'h3;
    logic [3:0] gt, bo;
    logic [1:0] rt;
    logic dc, ob, sk, il;
    int fail_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    always #2 ref_clk_in = ~ref_clk_in;
    sbg_ctrl_model u_ctl (.ref_clk_in(ref_clk_in), .cmd_in(cmd), .pins_out(p));
    sbg_gate_ctrl u_dut (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .gate_select_in(p[4]),
        .select_line_one_in(p[0]), .select_line_two_in(p[1]), .select_line_three_in(p[2]),
        .select_line_four_in(p[3]), .diff_pos_in(tp[3]), .diff_neg_in(tp[2]),
        .zero_cross_in(tp[1]), .qual_delay_in(tp[0]), .peak_in(pk), .channel_gate_out(gt),
        .discharge_out(dc), .observe_out(ob), .seek_mode_out(sk), .charge_rate_out(rt),
        .illegal_cmd_out(il), .burst_channel_one_out(bo[3]), .burst_channel_two_out(bo[2]),
        .burst_channel_three_out(bo[1]), .burst_channel_four_out(bo[0]));
    task chk(input string n, input logic [3:0] s, input logic [3:0] e);
        cmp_count++;
        if (s !== e) begin
            fail_count++;
            $display("[ERR] %s exp %h seen %h", n, e, s);
        end
    endtask : chk
    // model adds one edge, decode one, burst mux one more
    task apply(input logic [4:0] c, input logic [3:0] t);
        @(posedge ref_clk_in);
        cmd <= c;
        tp <= t;
        repeat (4) @(posedge ref_clk_in);
        @(negedge ref_clk_in);
    endtask : apply
    task conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : conclude
    task t_mode;
        apply(5'h04, 4'h0);
        chk("seek", sk, 4'h1);
        chk("rate", rt, SBG_RATE_FAST);
        apply(5'h00, 4'h0);
        chk("seek", sk, 4'h1);
        apply(5'h15, 4'h0);
        chk("seek", sk, 4'h1);
        apply(5'h01, 4'h0);
        chk("seek", sk, 4'h0);
        chk("rate", rt, SBG_RATE_SLOW);
        // controller drops line three, so the forbidden pair arrives as a track latch
        apply(5'h04, 4'h0);
        apply(5'h05, 4'h0);
        chk("refused", il, 4'h0);
        chk("seek", sk, 4'h0);
        $display("mode test done");
    endtask : t_mode
    task t_gate;
        for (int i = 0; i < 16; i++) begin
            apply({1'b1, 4'(i)}, 4'h0);
            chk("gate", gt, 4'(i));
        end
        $display("gate test done");
    endtask : t_gate
    task t_joint;
        apply(5'h04, 4'h0);
        apply(5'h0b, 4'ha);
        chk("discharge", dc, 4'h1);
        chk("observe", ob, 4'h1);
        chk("seek", sk, 4'h0);
        chk("burst", bo, 4'ha);
        chk("gate", gt, 4'h0);
        chk("refused", il, 4'h0);
        apply(5'h0b, 4'h5);
        chk("burst", bo, 4'h5);
        apply(5'h00, 4'h5);
        chk("burst", bo, 4'hc);
        chk("discharge", dc, 4'h0);
        chk("observe", ob, 4'h0);
        $display("joint test done");
    endtask : t_joint
    always @(posedge ref_clk_in) begin
        cyc++;
        if (cyc == 1000) begin
            fail_count++;
            conclude();
        end
    end
    initial begin
        repeat (12) @(posedge ref_clk_in);
        chk("seek", sk, 4'h0);
        chk("rate", rt, SBG_RATE_SLOW);
        rst_b_in <= 1'b1;
        $display("reset test done");
        t_mode();
        t_gate();
        t_joint();
        conclude();
    end
endmodule : sbg_gate_ctrl_bench
